// File: cdr_cfg.svh
// Constants for the banked data register file and memory map decode
// What this block does
// - Seven registers; four data, two address, frame base form one bank.
// - Two full bank copies; only one bank active for operands at once.
// - Four data registers, each 16 bits, general move and ALU operands.
// - Data registers 0 and 1 split into byte halves; half write keeps other.
// - Reg2:reg0 and reg3:reg1 join into 32-bit operands, upper word first.
// - Decoder covers the 1 Mbyte space from 00000h to FFFFFh.
// - Program memory ends at FFFFFh and extends downward by its capacity.
// - Fixed interrupt vectors occupy FFFDCh to FFFFFh for interrupt entry.
// - Data memory starts at 00400h and extends upward by its capacity.
// - Peripheral control area spans 00000h to 003FFh, routed to peripherals.
// - Special page vectors occupy FFE00h to FFFDBh for special page jumps.
// - Data memory also holds the stack for call and interrupt returns.
`ifndef CDR_CFG_SVH
`define CDR_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define CDR_AW 20
`define CDR_DW 16
`define CDR_BW 8
`define CDR_NDATA 4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CDR_RST_WORD 16'h0000

// ----------------------------------------
// Memory map
// ----------------------------------------
`define CDR_SPACE_LO 20'h00000
`define CDR_SPACE_HI 20'hfffff
`define CDR_PER_HI 20'h003ff
`define CDR_RAM_LO 20'h00400
`define CDR_RAM_SIZE 20'h01400
`define CDR_ROM_SIZE 20'h10000
`define CDR_SPV_LO 20'hffe00
`define CDR_SPV_HI 20'hfffdb
`define CDR_FIV_LO 20'hfffdc

`endif

// File: cdr_cpu_model.sv
// Execution-side model: issues writes, reads and decode probes
module cdr_cpu_model import cdr_pkg::*; (
	// Clock
	input wire logic clk_i,
	// Operand access
	output logic bank_sel_o,
	output cdr_wr_t wr_o,
	output cdr_sel_t rd_sel_o,
	input wire logic [31:0] rd_data_i,
	// Decode probe
	output logic [19:0] addr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		bank_sel_o = 1'b0;
		wr_o = '0;
		rd_sel_o = CDR_SEL_W0;
		addr_o = '0;
	end
	// Bank held with the write it qualifies
	task automatic put(input logic b, input cdr_sel_t s, input logic [31:0] v);
		@(negedge clk_i);
		bank_sel_o = b;
		wr_o = '{1'b1, s, v};
		@(negedge clk_i);
		wr_o = '{1'b0, s, ~v};
	endtask
	task automatic get(input logic b, input cdr_sel_t s, output logic [31:0] v);
		@(negedge clk_i);
		bank_sel_o = b;
		rd_sel_o = s;
		@(negedge clk_i);
		v = rd_data_i;
	endtask
	// Decode probes only; reserved holes never accessed
	task automatic at(input logic [19:0] a);
		@(negedge clk_i);
		addr_o = a;
		#1;
	endtask
endmodule

// File: cdr_map_dec.sv
// Memory map decoder for the 1 Mbyte address space
`include "cdr_cfg.svh"
module cdr_map_dec import cdr_pkg::*; (
	// Address in
	input wire logic [`CDR_AW-1:0] addr_i,
	// Decode out
	output cdr_dec_t dec_o
);

	// ----------------------------------------
	// Region decode
	// ----------------------------------------
	// 20-bit address always spans the full space
	logic rom_lo_ok;
	logic ram_hi_ok;
	assign rom_lo_ok = addr_i >= (`CDR_SPACE_HI - `CDR_ROM_SIZE + 20'h00001);
	assign ram_hi_ok = addr_i < (`CDR_RAM_LO + `CDR_RAM_SIZE);

	always_comb begin
		dec_o = '0;
		dec_o.region = CDR_RG_NONE;
		dec_o.rom_hit = rom_lo_ok;
		dec_o.ram_hit = (addr_i >= `CDR_RAM_LO) && ram_hi_ok;
		dec_o.per_hit = addr_i <= `CDR_PER_HI;
		dec_o.stack_ok = dec_o.ram_hit;
		if (addr_i >= `CDR_FIV_LO) begin
			dec_o.region = CDR_RG_FIV;
			dec_o.vec_hit = 1'b1;
			dec_o.offset = addr_i - `CDR_FIV_LO;
		end else if (addr_i >= `CDR_SPV_LO && addr_i <= `CDR_SPV_HI) begin
			dec_o.region = CDR_RG_SPV;
			dec_o.vec_hit = 1'b1;
			dec_o.offset = addr_i - `CDR_SPV_LO;
		end else if (rom_lo_ok) begin
			dec_o.region = CDR_RG_ROM;
			dec_o.offset = addr_i - (`CDR_SPACE_HI - `CDR_ROM_SIZE + 20'h00001);
		end else if (dec_o.ram_hit) begin
			dec_o.region = CDR_RG_RAM;
			dec_o.offset = addr_i - `CDR_RAM_LO;
		end else if (dec_o.per_hit) begin
			dec_o.region = CDR_RG_PER;
			dec_o.offset = addr_i - `CDR_SPACE_LO;
		end
	end

endmodule

// File: cdr_pkg.sv
// Types for the banked data register file and memory map decode
package cdr_pkg;

	// ----------------------------------------
	// Operand selection
	// ----------------------------------------
	typedef enum logic [3:0] {
		CDR_SEL_W0, CDR_SEL_W1, CDR_SEL_W2, CDR_SEL_W3,
		CDR_SEL_B0L, CDR_SEL_B0H, CDR_SEL_B1L, CDR_SEL_B1H,
		CDR_SEL_L20, CDR_SEL_L31,
		CDR_SEL_A0, CDR_SEL_A1, CDR_SEL_FB
	} cdr_sel_t;

	// ----------------------------------------
	// Memory regions
	// ----------------------------------------
	typedef enum logic [2:0] {
		CDR_RG_NONE, CDR_RG_PER, CDR_RG_RAM, CDR_RG_ROM,
		CDR_RG_SPV, CDR_RG_FIV
	} cdr_region_t;

	typedef struct packed {
		logic we;
		cdr_sel_t sel;
		logic [31:0] data;
	} cdr_wr_t;

	typedef struct packed {
		cdr_region_t region;
		logic rom_hit;
		logic ram_hit;
		logic per_hit;
		logic vec_hit;
		logic stack_ok;
		logic [19:0] offset;
	} cdr_dec_t;

endpackage

// File: cdr_regs.sv
// Banked data, address and frame base registers with map decode
`include "cdr_cfg.svh"
module cdr_regs import cdr_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Bank choice
	input wire logic bank_sel_i,
	// Write port
	input wire cdr_wr_t wr_i,
	// Read port
	input wire cdr_sel_t rd_sel_i,
	output logic [31:0] rd_data_o,
	// Address decode
	input wire logic [`CDR_AW-1:0] addr_i,
	output cdr_dec_t dec_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Seven words per bank, two banks
	logic [`CDR_DW-1:0] data_reg_r [2][`CDR_NDATA];
	logic [`CDR_DW-1:0] data_reg_nxt [2][`CDR_NDATA];
	logic [`CDR_DW-1:0] addr_reg_r [2][2];
	logic [`CDR_DW-1:0] addr_reg_nxt [2][2];
	logic [`CDR_DW-1:0] frame_base_reg_r [2];
	logic [`CDR_DW-1:0] frame_base_reg_nxt [2];
	logic [31:0] rd_data_r;
	logic [31:0] rd_data_nxt;

	function automatic logic [`CDR_DW-1:0] put_byte(
		input logic [`CDR_DW-1:0] w,
		input logic hi,
		input logic [`CDR_BW-1:0] b
	);
		put_byte = hi ? {b, w[`CDR_BW-1:0]} : {w[`CDR_DW-1:`CDR_BW], b};
	endfunction

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	always_comb begin
		data_reg_nxt = data_reg_r;
		addr_reg_nxt = addr_reg_r;
		frame_base_reg_nxt = frame_base_reg_r;
		if (wr_i.we) begin
			unique case (wr_i.sel)
				CDR_SEL_W0, CDR_SEL_W1, CDR_SEL_W2, CDR_SEL_W3: begin
					data_reg_nxt[bank_sel_i][wr_i.sel[1:0]] =
						wr_i.data[15:0];
				end
				CDR_SEL_B0L: begin
					data_reg_nxt[bank_sel_i][0] = put_byte(
						data_reg_r[bank_sel_i][0], 1'b0, wr_i.data[7:0]);
				end
				CDR_SEL_B0H: begin
					data_reg_nxt[bank_sel_i][0] = put_byte(
						data_reg_r[bank_sel_i][0], 1'b1, wr_i.data[7:0]);
				end
				CDR_SEL_B1L: begin
					data_reg_nxt[bank_sel_i][1] = put_byte(
						data_reg_r[bank_sel_i][1], 1'b0, wr_i.data[7:0]);
				end
				CDR_SEL_B1H: begin
					data_reg_nxt[bank_sel_i][1] = put_byte(
						data_reg_r[bank_sel_i][1], 1'b1, wr_i.data[7:0]);
				end
				CDR_SEL_L20: begin
					data_reg_nxt[bank_sel_i][2] = wr_i.data[31:16];
					data_reg_nxt[bank_sel_i][0] = wr_i.data[15:0];
				end
				CDR_SEL_L31: begin
					data_reg_nxt[bank_sel_i][3] = wr_i.data[31:16];
					data_reg_nxt[bank_sel_i][1] = wr_i.data[15:0];
				end
				CDR_SEL_A0: begin
					addr_reg_nxt[bank_sel_i][0] = wr_i.data[15:0];
				end
				CDR_SEL_A1: begin
					addr_reg_nxt[bank_sel_i][1] = wr_i.data[15:0];
				end
				CDR_SEL_FB: begin
					frame_base_reg_nxt[bank_sel_i] = wr_i.data[15:0];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Registered read: data shows one cycle after the select
	always_comb begin
		rd_data_nxt = 32'h0000_0000;
		unique case (rd_sel_i)
			CDR_SEL_W0, CDR_SEL_W1, CDR_SEL_W2, CDR_SEL_W3: begin
				rd_data_nxt[15:0] = data_reg_r[bank_sel_i][rd_sel_i[1:0]];
			end
			CDR_SEL_B0L: rd_data_nxt[7:0] = data_reg_r[bank_sel_i][0][7:0];
			CDR_SEL_B0H: rd_data_nxt[7:0] = data_reg_r[bank_sel_i][0][15:8];
			CDR_SEL_B1L: rd_data_nxt[7:0] = data_reg_r[bank_sel_i][1][7:0];
			CDR_SEL_B1H: rd_data_nxt[7:0] = data_reg_r[bank_sel_i][1][15:8];
			CDR_SEL_L20: begin
				rd_data_nxt = {data_reg_r[bank_sel_i][2],
					data_reg_r[bank_sel_i][0]};
			end
			CDR_SEL_L31: begin
				rd_data_nxt = {data_reg_r[bank_sel_i][3],
					data_reg_r[bank_sel_i][1]};
			end
			CDR_SEL_A0: rd_data_nxt[15:0] = addr_reg_r[bank_sel_i][0];
			CDR_SEL_A1: rd_data_nxt[15:0] = addr_reg_r[bank_sel_i][1];
			CDR_SEL_FB: rd_data_nxt[15:0] = frame_base_reg_r[bank_sel_i];
			default: rd_data_nxt = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int b = 0; b < 2; b++) begin
				for (int i = 0; i < `CDR_NDATA; i++) begin
					data_reg_r[b][i] <= `CDR_RST_WORD;
				end
				addr_reg_r[b][0] <= `CDR_RST_WORD;
				addr_reg_r[b][1] <= `CDR_RST_WORD;
				frame_base_reg_r[b] <= `CDR_RST_WORD;
			end
			rd_data_r <= 32'h0000_0000;
		end else begin
			data_reg_r <= data_reg_nxt;
			addr_reg_r <= addr_reg_nxt;
			frame_base_reg_r <= frame_base_reg_nxt;
			rd_data_r <= rd_data_nxt;
		end
	end

	assign rd_data_o = rd_data_r;

	// ----------------------------------------
	// Memory map
	// ----------------------------------------
	// Reserved peripheral holes are not flagged; software must avoid them
	cdr_map_dec i_cdr_map_dec (
		.addr_i(addr_i),
		.dec_o(dec_o)
	);

endmodule

// File: cdr_regs_checker.sv
// Assertions on the banked register file and map decode
module cdr_regs_checker import cdr_pkg::*; (
	// Watched ports
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic bank_sel_i,
	input wire cdr_wr_t wr_i,
	input wire cdr_sel_t rd_sel_i,
	input wire logic [31:0] rd_data_o,
	input wire logic [19:0] addr_i,
	input wire cdr_dec_t dec_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_per;
		addr_i <= 20'h003ff |-> dec_o.region == CDR_RG_PER && dec_o.per_hit;
	endproperty
	a_per: assert property (p_per) else $error("bad sfr decode");
	property p_ram;
		addr_i inside {[20'h00400:20'h017ff]} |->
			dec_o.region == CDR_RG_RAM && dec_o.offset == addr_i - 20'h00400;
	endproperty
	a_ram: assert property (p_ram) else $error("bad ram decode");
	property p_stk;
		dec_o.stack_ok == (addr_i inside {[20'h00400:20'h017ff]});
	endproperty
	a_stk: assert property (p_stk) else $error("bad stack flag");
	property p_rom;
		addr_i >= 20'hf0000 |-> dec_o.rom_hit;
	endproperty
	a_rom: assert property (p_rom) else $error("bad rom decode");
	property p_spv;
		addr_i inside {[20'hffe00:20'hfffdb]} |-> dec_o.region == CDR_RG_SPV;
	endproperty
	a_spv: assert property (p_spv) else $error("bad spv decode");
	property p_fiv;
		addr_i >= 20'hfffdc |-> dec_o.region == CDR_RG_FIV;
	endproperty
	a_fiv: assert property (p_fiv) else $error("bad fiv decode");
	property p_gap;
		addr_i inside {[20'h01800:20'heffff]} |-> dec_o.region == CDR_RG_NONE;
	endproperty
	a_gap: assert property (p_gap) else $error("bad gap decode");
	// Word written, then selected for read two cycles on, same bank
	property p_wr;
		wr_i.we && wr_i.sel inside {CDR_SEL_W0, CDR_SEL_W1, CDR_SEL_W2,
			CDR_SEL_W3} ##1 !wr_i.we ##1 !wr_i.we &&
			rd_sel_i == $past(wr_i.sel, 2) &&
			bank_sel_i == $past(bank_sel_i, 2)
			|=> rd_data_o == {16'h0000, $past(wr_i.data[15:0], 3)};
	endproperty
	a_wr: assert property (p_wr) else $error("bad word readback");
	c_wr: cover property (wr_i.we && bank_sel_i);
	c_spv: cover property (dec_o.region == CDR_RG_SPV);
	c_long: cover property (rd_sel_i == CDR_SEL_L31);
endmodule
bind cdr_regs cdr_regs_checker i_cdr_regs_checker (.clk_i, .rst_i,
	.bank_sel_i, .wr_i, .rd_sel_i, .rd_data_o, .addr_i, .dec_o);

// File: tb_cdr_regs.sv
// Testbench for the banked register file and map decode
module tb_cdr_regs import cdr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] MA [12] = '{20'h00000, 20'h003ff, 20'h00400,
		20'h017ff, 20'h01800, 20'heffff, 20'hf0000, 20'hffdff, 20'hffe00,
		20'hfffdb, 20'hfffdc, 20'hfffff};
	localparam cdr_region_t MR [12] = '{CDR_RG_PER, CDR_RG_PER,
		CDR_RG_RAM, CDR_RG_RAM, CDR_RG_NONE, CDR_RG_NONE, CDR_RG_ROM,
		CDR_RG_ROM, CDR_RG_SPV, CDR_RG_SPV, CDR_RG_FIV, CDR_RG_FIV};
	// Region base per probe; unmapped probes expect a zero offset
	localparam logic [19:0] MB [12] = '{20'h00000, 20'h00000, 20'h00400,
		20'h00400, 20'h01800, 20'heffff, 20'hf0000, 20'hf0000, 20'hffe00,
		20'hffe00, 20'hfffdc, 20'hfffdc};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic bank_sel_i;
	cdr_wr_t wr_i;
	cdr_sel_t rd_sel_i;
	logic [31:0] rd_data_o;
	logic [19:0] addr_i;
	cdr_dec_t dec_o;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [31:0] d;
	initial forever #5 clk_i = ~clk_i;
	cdr_regs i_cdr_regs (.clk_i, .rst_i, .bank_sel_i, .wr_i, .rd_sel_i,
		.rd_data_o, .addr_i, .dec_o);
	cdr_cpu_model i_cpu (.clk_i, .bank_sel_o(bank_sel_i), .wr_o(wr_i),
		.rd_sel_o(rd_sel_i), .addr_o(addr_i), .rd_data_i(rd_data_o));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, well above the roughly 140 cycles needed
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic t_bank();
		for (int k = 0; k < 4; k++)
			for (int i = 0; i < 13; i++)
				if (i < 4 || i > 9) begin
					if (k < 2) i_cpu.put(k[0], cdr_sel_t'(i), 32'h5a00 + 16 * k + i);
					else i_cpu.get(k[0], cdr_sel_t'(i), d);
					if (k > 1) chk(d, 32'h5a00 + 16 * (k - 2) + i);
				end
		$display("t_bank done");
	endtask
	task automatic t_byte();
		for (int r = 0; r < 2; r++) begin
			i_cpu.put(1'b1, cdr_sel_t'(r), 32'h1234);
			i_cpu.put(1'b1, cdr_sel_t'(4 + 2 * r), 32'hffab);
			i_cpu.put(1'b1, cdr_sel_t'(5 + 2 * r), 32'hffcd);
			i_cpu.get(1'b1, cdr_sel_t'(r), d);
			chk(d, 32'hcdab);
			i_cpu.get(1'b1, cdr_sel_t'(4 + 2 * r), d);
			chk(d, 32'h00ab);
			i_cpu.get(1'b1, cdr_sel_t'(5 + 2 * r), d);
			chk(d, 32'h00cd);
		end
		$display("t_byte done");
	endtask
	task automatic t_long();
		i_cpu.put(1'b0, CDR_SEL_L20, 32'h89abcdef);
		i_cpu.get(1'b0, CDR_SEL_L20, d);
		chk(d, 32'h89abcdef);
		i_cpu.get(1'b0, CDR_SEL_W2, d);
		chk(d, 32'h89ab);
		i_cpu.get(1'b0, CDR_SEL_W0, d);
		chk(d, 32'hcdef);
		i_cpu.put(1'b0, CDR_SEL_W3, 32'h1111);
		i_cpu.put(1'b0, CDR_SEL_W1, 32'h2222);
		i_cpu.get(1'b0, CDR_SEL_W1, d);
		chk(d, 32'h2222);
		i_cpu.get(1'b0, CDR_SEL_L31, d);
		chk(d, 32'h11112222);
		i_cpu.put(1'b0, CDR_SEL_L31, 32'h33334444);
		i_cpu.get(1'b0, CDR_SEL_W3, d);
		chk(d, 32'h3333);
		i_cpu.get(1'b0, CDR_SEL_W1, d);
		chk(d, 32'h4444);
		$display("t_long done");
	endtask
	task automatic t_map();
		for (int i = 0; i < 12; i++) begin
			i_cpu.at(MA[i]);
			chk({29'h0, dec_o.region}, {29'h0, MR[i]});
			chk({12'h0, dec_o.offset}, {12'h0, MA[i] - MB[i]});
			chk({31'h0, dec_o.vec_hit}, {31'h0, i > 7});
			chk({31'h0, dec_o.rom_hit}, {31'h0, i > 5});
			chk({31'h0, dec_o.per_hit}, {31'h0, i < 2});
			chk({31'h0, dec_o.ram_hit}, {31'h0, i == 2 || i == 3});
			chk({31'h0, dec_o.stack_ok}, {31'h0, i == 2 || i == 3});
		end
		$display("t_map done");
	endtask
	initial begin
		repeat (20) @(negedge clk_i);
		rst_i = 1'b0;
		i_cpu.get(1'b1, CDR_SEL_W3, d);
		chk(d, 32'h0);
		t_bank();
		t_byte();
		t_long();
		t_map();
		test_done();
	end
endmodule
